// >>> shared/pp_defines.svh
// constants for the profile position handshake block
// assumes 16-bit cyclic process data words from the host
`ifndef PP_DEFINES_SVH
`define PP_DEFINES_SVH

// mode selector value that selects profile position operation
`define PP_MODE_PROFILE_POS 16'h0001

// command word bit positions
`define CMD_SWITCH_ON 0
`define CMD_EN_VOLTAGE 1
`define CMD_QUICK_STOP_N 2
`define CMD_EN_OPERATION 3
`define CMD_NEW_SETPOINT 4
`define CMD_CHANGE_NOW 5
`define CMD_RELATIVE 6
`define CMD_FAULT_RESET 7
`define CMD_HALT 8
`define CMD_CHANGE_ON_SP 9

// state word bit positions
`define ST_READY 0
`define ST_SWITCHED_ON 1
`define ST_OP_ENABLED 2
`define ST_FAULT 3
`define ST_VOLTAGE 4
`define ST_QUICK_STOP_N 5
`define ST_SW_ON_DISABLED 6
`define ST_WARNING 7
`define ST_REMOTE 9
`define ST_TARGET_REACHED 10
`define ST_INT_LIMIT 11
`define ST_SP_ACK 12
`define ST_FOLLOW_ERR 13
`define ST_WARNING2 15

// ramp parameters held in the configuration store
`define RAMP_PARAM_FIRST 1176
`define RAMP_PARAM_LAST 1178

// reset values
`define STATE_WORD_RESET 16'h0000
`define MODE_ECHO_RESET 16'h0000

`endif

// >>> shared/motion_pkg.sv
// types for the profile position handshake block
// assumes pp_defines.svh for the numeric constants
package motion_pkg;

  typedef enum logic [2:0] {
    SW_ON_DISABLED,
    READY_TO_SW_ON,
    SWITCHED_ON,
    OP_ENABLED,
    FAULT
  } drive_state_t;

  // ramp times from configuration parameters 1176, 1177, 1178
  typedef struct packed {
    logic [15:0] ramp_first;
    logic [15:0] ramp_second;
    logic [15:0] ramp_third;
  } ramp_cfg_t;

  // one positioning move handed to the profile calculation
  typedef struct packed {
    logic [31:0] target;
    logic relative;
    logic change_on_sp;
    logic change_now;
    ramp_cfg_t ramps;
  } move_req_t;

endpackage : motion_pkg

// >>> design/profile_position_handshake.sv
// profile position mode handshake: command word decode, drive state
// machine, set-point queue and state word assembly
// assumes one cyclic slot update per i_slot_valid pulse, and a motion
// profile engine outside that consumes o_move_req on o_move_start
`timescale 1ns/100ps
`default_nettype none
`include "pp_defines.svh"

// How it works
// - profile position only when mode selector is 1
// - moves start on command edge, not position
// - ramp times from parameters 1176 to 1178
// - command bits 0-3 power control, 7 fault reset
// - plain edge queues until current target reached
// - immediate bit starts new move at once
// - change-on-set-point blends into next move
// - relative bit selects absolute or relative target
// - halt decelerates, stays operation enabled
// - acknowledge set once calculation took value
// - state word bit map
// - active mode echoed beside state word
// - host clears new set-point, then acknowledge drops
// - 0x0006, 0x0007, 0x000f enable sequence
module profile_position_handshake (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_slot_valid,
  input wire logic [15:0] i_host_command_slot,
  input wire logic [15:0] i_host_mode_select_slot,
  input wire logic [31:0] i_target_position_slot,
  input wire motion_pkg::ramp_cfg_t i_ramp_cfg,
  input wire logic i_axis_at_target,
  input wire logic i_axis_speed_zero,
  input wire logic i_following_error,
  input wire logic i_internal_limit,
  input wire logic i_fault_event,
  input wire logic i_warning,
  input wire logic i_warning2,
  input wire logic i_remote,
  output logic [15:0] o_drive_state_slot,
  output logic [15:0] o_drive_mode_echo_slot,
  output logic o_move_start,
  output motion_pkg::move_req_t o_move_req,
  output logic o_halt
);
  // ---------------------------------------------------------------
  // received slots
  // ---------------------------------------------------------------
  logic [15:0] cmd_r;
  logic [15:0] mode_r;
  logic nsp_prev_r;
  logic fr_prev_r;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cmd_r <= 16'h0000;
      mode_r <= `MODE_ECHO_RESET;
      nsp_prev_r <= 1'b0;
      fr_prev_r <= 1'b0;
    end
    else if (i_slot_valid)
    begin
      cmd_r <= i_host_command_slot;
      mode_r <= i_host_mode_select_slot;
      nsp_prev_r <= i_host_command_slot[`CMD_NEW_SETPOINT];
      fr_prev_r <= i_host_command_slot[`CMD_FAULT_RESET];
    end
  end
  logic nsp_edge;
  logic fr_edge;
  assign nsp_edge = i_slot_valid & i_host_command_slot[`CMD_NEW_SETPOINT]
                    & ~nsp_prev_r;
  assign fr_edge = i_slot_valid & i_host_command_slot[`CMD_FAULT_RESET]
                   & ~fr_prev_r;
  // ---------------------------------------------------------------
  // drive state machine
  // ---------------------------------------------------------------
  motion_pkg::drive_state_t state_r;
  logic power_ok;
  assign power_ok = cmd_r[`CMD_EN_VOLTAGE] & cmd_r[`CMD_QUICK_STOP_N];
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      state_r <= motion_pkg::SW_ON_DISABLED;
    else if (i_fault_event)
      state_r <= motion_pkg::FAULT;
    else
    begin
      case (state_r)
        motion_pkg::SW_ON_DISABLED:
          if (power_ok && !cmd_r[`CMD_SWITCH_ON])
            state_r <= motion_pkg::READY_TO_SW_ON;
        motion_pkg::READY_TO_SW_ON:
          if (!power_ok)
            state_r <= motion_pkg::SW_ON_DISABLED;
          else if (cmd_r[`CMD_SWITCH_ON])
            state_r <= motion_pkg::SWITCHED_ON;
        motion_pkg::SWITCHED_ON:
          if (!power_ok)
            state_r <= motion_pkg::SW_ON_DISABLED;
          else if (!cmd_r[`CMD_SWITCH_ON])
            state_r <= motion_pkg::READY_TO_SW_ON;
          else if (cmd_r[`CMD_EN_OPERATION])
            state_r <= motion_pkg::OP_ENABLED;
        motion_pkg::OP_ENABLED:
          if (!power_ok)
            state_r <= motion_pkg::SW_ON_DISABLED;
          else if (!cmd_r[`CMD_SWITCH_ON])
            state_r <= motion_pkg::READY_TO_SW_ON;
          else if (!cmd_r[`CMD_EN_OPERATION])
            state_r <= motion_pkg::SWITCHED_ON;
        motion_pkg::FAULT:
          if (fr_edge)
            state_r <= motion_pkg::SW_ON_DISABLED;
        default:
          state_r <= motion_pkg::SW_ON_DISABLED;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // set-point handshake and queue
  // ---------------------------------------------------------------
  logic pp_run;
  logic halt;
  logic accept;
  logic start_new;
  logic start_pend;
  logic start_now;
  logic busy_r;
  logic pend_r;
  logic ack_r;
  motion_pkg::move_req_t pend_req_r;
  motion_pkg::move_req_t new_req;
  assign pp_run = (state_r == motion_pkg::OP_ENABLED)
                  && (mode_r == `PP_MODE_PROFILE_POS);
  assign halt = cmd_r[`CMD_HALT];
  // a new edge is refused while the previous acknowledge is still set or a move is queued
  assign accept = nsp_edge & pp_run & ~ack_r & ~pend_r
                  & (i_host_mode_select_slot == `PP_MODE_PROFILE_POS);
  assign start_new = accept & ~halt
                     & (i_host_command_slot[`CMD_CHANGE_NOW] | ~busy_r);
  // queued move waits for the running one; halt also holds it back
  assign start_pend = pend_r & pp_run & ~halt
                      & (~busy_r | i_axis_at_target);
  assign start_now = start_new | start_pend;
  always_comb
  begin
    new_req.target = i_target_position_slot;
    new_req.relative = i_host_command_slot[`CMD_RELATIVE];
    new_req.change_on_sp = i_host_command_slot[`CMD_CHANGE_ON_SP];
    new_req.change_now = i_host_command_slot[`CMD_CHANGE_NOW];
    new_req.ramps = i_ramp_cfg;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !pp_run)
    begin
      pend_r <= 1'b0;
      pend_req_r <= '0;
    end
    else if (accept && !start_new)
    begin
      pend_r <= 1'b1;
      pend_req_r <= new_req;
    end
    else if (start_pend)
      pend_r <= 1'b0;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || !pp_run)
      busy_r <= 1'b0;
    else if (start_now)
      busy_r <= 1'b1;
    else if (i_axis_at_target)
      busy_r <= 1'b0;
  end
  // set wins over the host's release of the new set-point bit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      ack_r <= 1'b0;
    else if (start_now)
      ack_r <= 1'b1;
    else if (!cmd_r[`CMD_NEW_SETPOINT])
      ack_r <= 1'b0;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_move_start <= 1'b0;
      o_move_req <= '0;
    end
    else
    begin
      o_move_start <= start_now;
      if (start_new)
        o_move_req <= new_req;
      else if (start_pend)
        o_move_req <= pend_req_r;
    end
  end
  // ---------------------------------------------------------------
  // state word and mode echo
  // ---------------------------------------------------------------
  logic [15:0] state_word;
  logic reached;
  // with halt the bit tells standstill, otherwise the move is done
  assign reached = halt ? i_axis_speed_zero : (~busy_r & ~pend_r);
  always_comb
  begin
    state_word = 16'h0000;
    case (state_r)
      motion_pkg::SW_ON_DISABLED:
        state_word[`ST_SW_ON_DISABLED] = 1'b1;
      motion_pkg::READY_TO_SW_ON:
        state_word[`ST_READY] = 1'b1;
      motion_pkg::SWITCHED_ON:
        state_word[`ST_SWITCHED_ON:`ST_READY] = 2'b11;
      motion_pkg::OP_ENABLED:
        state_word[`ST_OP_ENABLED:`ST_READY] = 3'b111;
      motion_pkg::FAULT:
        state_word[`ST_FAULT] = 1'b1;
      default:
        state_word[`ST_SW_ON_DISABLED] = 1'b1;
    endcase
    state_word[`ST_VOLTAGE] = cmd_r[`CMD_EN_VOLTAGE];
    state_word[`ST_QUICK_STOP_N] = (state_r != motion_pkg::SW_ON_DISABLED)
                                   && (state_r != motion_pkg::FAULT)
                                   && cmd_r[`CMD_QUICK_STOP_N];
    state_word[`ST_WARNING] = i_warning;
    state_word[`ST_REMOTE] = i_remote;
    state_word[`ST_TARGET_REACHED] = pp_run & reached;
    state_word[`ST_INT_LIMIT] = i_internal_limit;
    state_word[`ST_SP_ACK] = ack_r;
    state_word[`ST_FOLLOW_ERR] = i_following_error;
    state_word[`ST_WARNING2] = i_warning2;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_drive_state_slot <= `STATE_WORD_RESET;
      o_drive_mode_echo_slot <= `MODE_ECHO_RESET;
      o_halt <= 1'b0;
    end
    else
    begin
      o_drive_state_slot <= state_word;
      o_drive_mode_echo_slot <= mode_r;
      o_halt <= pp_run & halt;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  a_mode_gate: assert property (
    o_move_start |-> $past(mode_r) == `PP_MODE_PROFILE_POS)
    else $error("move started outside profile position mode");
  a_start_cause: assert property (
    o_move_start |-> $past(accept) || $past(pend_r))
    else $error("move started without a set-point command");
  a_queue_wait: assert property (
    pend_r && busy_r && !i_axis_at_target |=> !o_move_start)
    else $error("queued move started before target reached");
  a_immediate_go: assert property (
    accept && !halt && i_host_command_slot[`CMD_CHANGE_NOW]
    |=> o_move_start ##1 !o_move_start)
    else $error("immediate set-point did not start at once");
  a_ack_with_start: assert property (
    o_move_start |-> ack_r ##1 o_drive_state_slot[`ST_SP_ACK])
    else $error("acknowledge missing after move start");
  a_ack_release: assert property (
    ack_r && !cmd_r[`CMD_NEW_SETPOINT] && !start_now |=> !ack_r)
    else $error("acknowledge held after host released set-point");
  a_halt_drive: assert property (
    pp_run && halt && power_ok && !i_fault_event
    && cmd_r[`CMD_SWITCH_ON] && cmd_r[`CMD_EN_OPERATION]
    |=> o_halt && state_r == motion_pkg::OP_ENABLED)
    else $error("halt did not reach output or left enabled state");
  a_fault_clear: assert property (
    state_r == motion_pkg::FAULT && fr_edge && !i_fault_event
    |=> state_r == motion_pkg::SW_ON_DISABLED)
    else $error("fault reset edge did not leave fault state");
  a_rel_flag: assert property (
    start_new |=> o_move_req.relative == $past(
      i_host_command_slot[`CMD_RELATIVE]))
    else $error("relative flag not carried into move");
endmodule : profile_position_handshake
`default_nettype wire

// >>> bench/plc_host_model.sv
// controller model: drives the cyclic host slots of the drive
// assumes the bench supplies the clock and calls its tasks
`timescale 1ns/100ps
`default_nettype none
module plc_host_model (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_drive_state_slot,
  output logic o_slot_valid,
  output logic [15:0] o_host_command_slot,
  output logic [15:0] o_host_mode_select_slot,
  output logic [31:0] o_target_position_slot
);
  initial
  begin
    o_slot_valid = 1'b0;
    o_host_command_slot = 16'h0000;
    o_host_mode_select_slot = 16'h0001;
    o_target_position_slot = 32'h0000_0000;
  end

  // ----
  // cycle tasks
  // ----
  // slots change at the falling edge, one received cycle per call
  task automatic send(input logic [15:0] cmd, input logic [31:0] tgt);
  begin
    @(negedge i_clk_sys);
    o_host_command_slot = cmd;
    o_target_position_slot = tgt;
    o_slot_valid = 1'b1;
    @(negedge i_clk_sys);
    o_slot_valid = 1'b0;
  end
  endtask : send

  task automatic select_mode(input logic [15:0] m);
  begin
    o_host_mode_select_slot = m;
  end
  endtask : select_mode

  task automatic wait_bit(input int idx, input logic v, output logic ok);
    int n;
  begin
    n = 0;
    while (i_drive_state_slot[idx] !== v && n < 10)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = (n < 10);
  end
  endtask : wait_bit

  // each step waits for its response before the next word goes out
  task automatic power_up(output logic ok);
    logic [15:0] seq [3];
    logic [7:0] resp [3];
    int n;
  begin
    seq = '{16'h0006, 16'h0007, 16'h000f};
    resp = '{8'h31, 8'h33, 8'h37};
    ok = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      send(seq[k], 32'h0000_0000);
      n = 0;
      while (i_drive_state_slot[7:0] !== resp[k] && n < 10)
      begin
        @(negedge i_clk_sys);
        n++;
      end
      if (n == 10)
        ok = 1'b0;
    end
  end
  endtask : power_up
endmodule : plc_host_model
`default_nettype wire

// >>> bench/profile_position_handshake_bench.sv
// self-checking bench for the profile position handshake
// assumes plc_host_model drives the host slots
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 48'(e), 48'(g))
module profile_position_handshake_bench;
  logic i_clk_sys, i_reset, sv, at_t, spd0, fault, ok, mstart, halt;
  logic [15:0] cmd, mode, st, echo;
  logic [31:0] tgt;
  logic [4:0] fl;
  motion_pkg::move_req_t req;
  motion_pkg::ramp_cfg_t rc;
  int errors, checks, cycles, starts;

  plc_host_model host (.i_clk_sys(i_clk_sys), .i_drive_state_slot(st),
    .o_slot_valid(sv), .o_host_command_slot(cmd),
    .o_host_mode_select_slot(mode), .o_target_position_slot(tgt));
  profile_position_handshake uut (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_slot_valid(sv), .i_host_command_slot(cmd),
    .i_host_mode_select_slot(mode), .i_target_position_slot(tgt),
    .i_ramp_cfg(rc), .i_axis_at_target(at_t), .i_axis_speed_zero(spd0),
    .i_following_error(fl[0]), .i_internal_limit(fl[1]),
    .i_fault_event(fault), .i_warning(fl[2]), .i_warning2(fl[3]),
    .i_remote(fl[4]), .o_drive_state_slot(st),
    .o_drive_mode_echo_slot(echo), .o_move_start(mstart),
    .o_move_req(req), .o_halt(halt));

  // ----
  // clock, watchdog, reporting
  // ----
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (mstart === 1'b1)
      starts++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [47:0] e, g);
  begin
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : check

  task automatic complete_run();
  begin
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask : complete_run

  // ----
  // tests
  // ----
  initial
  begin
    i_reset = 1'b1;
    at_t = 1'b1;
    spd0 = 1'b0;
    fault = 1'b0;
    fl = 5'h00;
    rc = 48'h0a0b_0c0d_0e0f;
    repeat (20) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    `CHK("state_reset", 16'h0040, st);
    host.power_up(ok);
    `CHK("power_up", 1'b1, ok);
    `CHK("mode_echo", 16'h0001, echo);
    fl = 5'h1f;
    repeat (3) @(negedge i_clk_sys);
    `CHK("flag_bits", 16'haa80, st & 16'haa80);
    fl = 5'h00;
    $display("test power done");
    starts = 0;
    host.send(16'h004f, 32'h1234_5678);
    repeat (3) @(negedge i_clk_sys);
    `CHK("no_start_on_target", 0, starts);
    host.send(16'h005f, 32'h1234_5678);
    host.wait_bit(12, 1'b1, ok);
    `CHK("ack_set", 1'b1, ok);
    `CHK("one_start", 1, starts);
    `CHK("req_target", 32'h1234_5678, req.target);
    `CHK("req_rel", 1'b1, req.relative);
    `CHK("req_ramps", 48'h0a0b_0c0d_0e0f, req.ramps);
    host.send(16'h004f, 32'h1234_5678);
    host.wait_bit(12, 1'b0, ok);
    `CHK("ack_clear", 1'b1, ok);
    $display("test setpoint done");
    at_t = 1'b0;
    starts = 0;
    host.send(16'h021f, 32'h0000_0100);
    host.wait_bit(12, 1'b1, ok);
    host.send(16'h020f, 32'h0000_0100);
    host.wait_bit(12, 1'b0, ok);
    host.send(16'h021f, 32'h0000_0200);
    repeat (6) @(negedge i_clk_sys);
    `CHK("queued_wait", 1, starts);
    `CHK("queued_no_ack", 1'b0, st[12]);
    at_t = 1'b1;
    host.wait_bit(12, 1'b1, ok);
    `CHK("queued_start", 2, starts);
    `CHK("queued_cosp", 1'b1, req.change_on_sp);
    `CHK("queued_tgt", 32'h0000_0200, req.target);
    host.send(16'h020f, 32'h0000_0200);
    host.wait_bit(12, 1'b0, ok);
    $display("test queued done");
    at_t = 1'b0;
    starts = 0;
    host.send(16'h001f, 32'h0000_0300);
    host.wait_bit(12, 1'b1, ok);
    host.send(16'h000f, 32'h0000_0300);
    host.wait_bit(12, 1'b0, ok);
    host.send(16'h003f, 32'h0000_0400);
    host.wait_bit(12, 1'b1, ok);
    `CHK("now_start", 2, starts);
    `CHK("now_flag", 1'b1, req.change_now);
    `CHK("now_tgt", 32'h0000_0400, req.target);
    host.send(16'h002f, 32'h0000_0400);
    host.wait_bit(12, 1'b0, ok);
    $display("test immediate done");
    host.send(16'h010f, 32'h0000_0400);
    repeat (4) @(negedge i_clk_sys);
    `CHK("halt_out", 1'b1, halt);
    `CHK("halt_enabled", 8'h37, st[7:0]);
    `CHK("halt_decel", 1'b0, st[10]);
    spd0 = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    `CHK("halt_stopped", 1'b1, st[10]);
    at_t = 1'b1;
    host.send(16'h000f, 32'h0000_0400);
    repeat (4) @(negedge i_clk_sys);
    `CHK("reached", 1'b1, st[10]);
    $display("test halt done");
    starts = 0;
    host.select_mode(16'h0003);
    host.send(16'h001f, 32'h0000_0500);
    repeat (6) @(negedge i_clk_sys);
    `CHK("other_mode", 0, starts);
    `CHK("echo_other", 16'h0003, echo);
    $display("test mode done");
    fault = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    `CHK("fault_bits", 16'h0008, st & 16'h004f);
    fault = 1'b0;
    host.send(16'h0080, 32'h0000_0000);
    repeat (3) @(negedge i_clk_sys);
    `CHK("fault_reset", 16'h0040, st & 16'h004f);
    $display("test fault done");
    complete_run();
  end
endmodule : profile_position_handshake_bench
`default_nettype wire
